// file: rtl/pms_map.vh
// Command codes, field positions, reset values and timing constants of the power module sequencer.
`ifndef PMS_MAP_VH
`define PMS_MAP_VH
// Command codes of the register port.
`define PMS_CMD_OPERATION 8'h01
`define PMS_CMD_ENSRC 8'h02
`define PMS_CMD_SETPOINT 8'h21
`define PMS_CMD_SLEW 8'h27
`define PMS_CMD_OVWARN 8'h57
`define PMS_CMD_GOODWIN 8'h5e
`define PMS_CMD_TON_WAIT 8'h60
`define PMS_CMD_TON_RAMP 8'h61
`define PMS_CMD_TOFF_WAIT 8'h64
`define PMS_CMD_TOFF_RAMP 8'h65
`define PMS_CMD_PINCFG 8'hd1
`define PMS_CMD_GOOD_WAIT 8'hd4
`define PMS_CMD_CHAIN 8'he0
`define PMS_CMD_FOLLOW 8'he1
`define PMS_CMD_STATUS 8'hd8
// Reset values.
`define PMS_RST_OPERATION 8'h00
`define PMS_RST_ENSRC 8'h05
`define PMS_RST_SLEW 16'h0001
`define PMS_RST_OVWARN 16'h0960
`define PMS_RST_GOODWIN 16'h000a
`define PMS_RST_TON_WAIT 16'h0032
`define PMS_RST_TON_RAMP 16'h0032
`define PMS_RST_TOFF_WAIT 16'h0000
`define PMS_RST_TOFF_RAMP 16'h0032
`define PMS_RST_ZERO16 16'h0000
`define PMS_RST_ZERO8 8'h00
// Field positions.
`define PMS_OP_ON 7
`define PMS_EN_PIN 0
`define PMS_EN_CMD 1
`define PMS_EN_SOFT 2
`define PMS_FOL_EN 0
`define PMS_FOL_RATIO 1
`define PMS_FOL_LIMIT 2
`define PMS_PIN_INV 0
`define PMS_CHAIN_PRE 4:0
`define PMS_CHAIN_NEXT 9:5
`define PMS_CHAIN_HAS_PRE 10
`define PMS_CHAIN_HAS_NEXT 11
`define PMS_MSG_ON 7
`define PMS_MSG_ID 4:0
`define PMS_STRAP_ADDR 4:0
`define PMS_STRAP_SET 7:5
// Discrete strap setpoints and the fallback, in millivolts.
`define PMS_SET0 16'h0258
`define PMS_SET1 16'h02ee
`define PMS_SET2 16'h0384
`define PMS_SET3 16'h03e8
`define PMS_SET4 16'h044c
`define PMS_SET5 16'h04b0
`define PMS_SET6 16'h05dc
`define PMS_SET7 16'h0708
`define PMS_FALLBACK_MV 16'h0708
// Timing: clock rate in MHz, tick in microseconds, initialization in milliseconds.
`define PMS_CLK_MHZ 32'h0000000a
`define PMS_TICK_US 32'h00000064
`define PMS_INIT_MS 32'h0000000f
`define PMS_PCT_FULL 32'h00000064
`endif

// file: rtl/pms_power_sequencer.v
// Start-up, enable, ramp, power-good, tracking and chain control of a point-of-load module.
// Summary of operation
// RQ1: Above power-on level, load strap, defaults, user store.
// RQ2: Commands and enable accepted only after initialization.
// RQ3: Later sources override earlier; bus writes win.
// RQ4: Strap picks address and setpoint; command overrides.
// RQ5: Faulty strap gives 1.8 V unless stored.
// RQ6: Enable pin high means on, low off.
// RQ7: Enable source config selects pin and/or command.
// RQ8: Enable edges; edges mid-sequence are ignored.
// RQ9: Host keeps enable pulses wide enough.
// RQ10: Wait programmable delay; zero means one tick.
// RQ11: Ramp slopes follow programmed rise/fall times.
// RQ12: Output good only in window, no fault.
// RQ13: Output good waits programmed delay.
// RQ14: Low pre-bias: start at it, ramp up.
// RQ15: High pre-bias: after rise time, ramp down.
// RQ16: Pre-bias above warning limit: stay off.
// RQ17: Tracking: coincident clipped or half ratio.
// RQ18: Tracking ignores enable, delays, limited setpoint.
// RQ19: Tracked signal slow; enable before it rises.
// RQ20: Tracked input above zero: slew to ratio.
// RQ21: On output good, notify next module.
// RQ22: After own fall, notify previous module.
// RQ23: Chain messages carry type and sender id.
`include "pms_map.vh"
`timescale 1ns/100ps
`default_nettype none

module pms_power_sequencer #(
  // Initialization time in cycles; shorten in simulation.
  parameter INIT_CYCLES = `PMS_INIT_MS * 32'd1000 * `PMS_CLK_MHZ,
  // Cycles of one timing tick.
  parameter TICK_CYCLES = `PMS_TICK_US * `PMS_CLK_MHZ
) (
  // Clock and reset.
  input wire mclk_i,
  input wire reset_i,
  // Supply monitor and straps.
  input wire por_ok_i,
  input wire [7:0] strap_divider_input_i,
  input wire strap_fault_i,
  input wire nv_setpoint_valid_i,
  input wire [15:0] nv_setpoint_i,
  // Enable pin.
  input wire enable_pin_i,
  // Command port.
  input wire cmd_wr_i,
  input wire cmd_rd_i,
  input wire [7:0] cmd_code_i,
  input wire [15:0] cmd_wdata_i,
  output reg [15:0] cmd_rdata_o,
  output reg cmd_ready_o,
  // Power stage view.
  input wire [15:0] vout_meas_i,
  input wire fault_i,
  input wire [15:0] follow_reference_input_i,
  output reg [15:0] vout_ref_o,
  output reg switching_o,
  output reg output_ok_signal_o,
  output reg [4:0] bus_address_o,
  // Inter-module bus, open drain data.
  input wire imb_clk_i,
  input wire imb_data_i,
  output reg imb_data_o,
  output reg imb_data_oe_o
);

  // One-hot states.
  localparam [10:0] ST_INIT = 11'h001;
  localparam [10:0] ST_OFF = 11'h002;
  localparam [10:0] ST_WAITPRE = 11'h004;
  localparam [10:0] ST_DELAY = 11'h008;
  localparam [10:0] ST_HOLD = 11'h010;
  localparam [10:0] ST_RAMP = 11'h020;
  localparam [10:0] ST_ON = 11'h040;
  localparam [10:0] ST_OFFWAIT = 11'h080;
  localparam [10:0] ST_OFFDLY = 11'h100;
  localparam [10:0] ST_FALL = 11'h200;
  localparam [10:0] ST_TRACK = 11'h400;

  // Synchroniser stages for supply, enable, link clock and link data.
  reg [3:0] s1_reg;
  reg [3:0] s2_reg;
  reg [3:0] s3_reg;
  reg [3:0] filt_reg;
  reg [3:0] filt_d_reg;
  wire [3:0] raw = {imb_data_i, imb_clk_i, enable_pin_i, por_ok_i};
  wire por_ok = filt_reg[0];
  wire en_rise = filt_reg[1] & ~filt_d_reg[1];
  wire en_fall = ~filt_reg[1] & filt_d_reg[1];
  wire lk_rise = filt_reg[2] & ~filt_d_reg[2];
  wire lk_fall = ~filt_reg[2] & filt_d_reg[2];
  wire lk_data = filt_reg[3];

  // A change is taken only once the second and third stages agree.
  always @(posedge mclk_i) begin
    if (reset_i) begin
      // Stages start at the idle levels so that leaving reset shows no false link edge.
      s1_reg <= 4'hc;
      s2_reg <= 4'hc;
      s3_reg <= 4'hc;
      filt_reg <= 4'hc;
      filt_d_reg <= 4'hc;
    end else begin
      s1_reg <= raw;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      filt_reg <= (s2_reg & s3_reg) | (filt_reg & (s2_reg | s3_reg));
      filt_d_reg <= filt_reg;
    end
  end

  // Free-running tick that all programmed times count in.
  reg [31:0] tick_cnt_reg;
  wire tick = (tick_cnt_reg == TICK_CYCLES - 1);
  always @(posedge mclk_i) begin
    if (reset_i) begin
      tick_cnt_reg <= 32'h0;
    end else begin
      tick_cnt_reg <= tick ? 32'h0 : tick_cnt_reg + 32'h1;
    end
  end

  // Programmed registers.
  reg [7:0] op_reg;
  reg [7:0] ensrc_reg;
  reg [15:0] setpoint_reg;
  reg [15:0] slew_reg;
  reg [15:0] ovwarn_reg;
  reg [15:0] goodwin_reg;
  reg [15:0] ton_wait_reg;
  reg [15:0] ton_ramp_reg;
  reg [15:0] toff_wait_reg;
  reg [15:0] toff_ramp_reg;
  reg [15:0] pincfg_reg;
  reg [15:0] good_wait_reg;
  reg [15:0] chain_reg;
  reg [7:0] follow_reg;

  // Sequencing state.
  reg [10:0] state_reg;
  reg [31:0] init_cnt_reg;
  reg [15:0] wait_cnt_reg;
  reg pin_on_reg;
  reg inhibit_reg;
  reg [31:0] acc_reg;
  reg [31:0] span_reg;
  reg [31:0] ramp_cyc_reg;
  reg dir_up_reg;
  reg [15:0] goal_reg;
  reg catch_reg;
  reg [15:0] limit_reg;
  reg [15:0] good_cnt_reg;
  reg good_reg;
  reg tx_req_reg;
  reg tx_on_reg;

  // Link receive and transmit state.
  reg [7:0] rx_sh_reg;
  reg [3:0] rx_cnt_reg;
  reg rx_valid_reg;
  reg [7:0] rx_msg_reg;
  reg [8:0] tx_sh_reg;
  reg [3:0] tx_cnt_reg;

  // Derived conditions.
  wire ready = (state_reg != ST_INIT);
  wire cmd_on = op_reg[`PMS_OP_ON];
  wire use_pin = ensrc_reg[`PMS_EN_PIN];
  wire use_cmd = ensrc_reg[`PMS_EN_CMD];
  wire soft_off = ensrc_reg[`PMS_EN_SOFT];
  wire fol_en = follow_reg[`PMS_FOL_EN];
  wire fol_lim = follow_reg[`PMS_FOL_LIMIT];
  wire has_pre = chain_reg[`PMS_CHAIN_HAS_PRE];
  wire has_next = chain_reg[`PMS_CHAIN_HAS_NEXT];
  wire stable = (state_reg == ST_OFF) || (state_reg == ST_ON);
  wire [15:0] on_wait = (ton_wait_reg == 16'h0) ? 16'h1 : ton_wait_reg;
  wire [15:0] off_wait = (toff_wait_reg == 16'h0) ? 16'h1 : toff_wait_reg;
  wire [31:0] rise_cyc = ton_ramp_reg * TICK_CYCLES;
  wire [31:0] fall_cyc = toff_ramp_reg * TICK_CYCLES;
  wire [15:0] target = (fol_en && fol_lim) ? limit_reg : setpoint_reg;

  // Source combination: none selected means always on.
  reg want_on;
  always @* begin
    case ({use_cmd, use_pin})
      2'b01: want_on = pin_on_reg;
      2'b10: want_on = cmd_on;
      2'b11: want_on = pin_on_reg & cmd_on;
      default: want_on = 1'b1;
    endcase
  end

  // Strap table lookup.
  reg [15:0] strap_mv;
  always @* begin
    case (strap_divider_input_i[`PMS_STRAP_SET])
      3'h0: strap_mv = `PMS_SET0;
      3'h1: strap_mv = `PMS_SET1;
      3'h2: strap_mv = `PMS_SET2;
      3'h3: strap_mv = `PMS_SET3;
      3'h4: strap_mv = `PMS_SET4;
      3'h5: strap_mv = `PMS_SET5;
      3'h6: strap_mv = `PMS_SET6;
      default: strap_mv = `PMS_SET7;
    endcase
  end

  // Tracking goal: half the reference, or the reference clipped at target.
  wire [15:0] ref_in = follow_reference_input_i;
  wire [15:0] trk_goal = follow_reg[`PMS_FOL_RATIO] ? {1'b0, ref_in[15:1]} : // RQ17
                         ((ref_in > target) ? target : ref_in);
  wire [15:0] trk_diff = (vout_ref_o > trk_goal) ? vout_ref_o - trk_goal : trk_goal - vout_ref_o;

  // Window check; goodwin_reg holds the window in percent.
  wire [15:0] err = (vout_meas_i > vout_ref_o) ? vout_meas_i - vout_ref_o : vout_ref_o - vout_meas_i;
  wire [31:0] err_scaled = err * `PMS_PCT_FULL;
  wire [31:0] win_scaled = vout_ref_o * goodwin_reg;
  wire good_cond = switching_o && ((state_reg == ST_ON) || (state_reg == ST_TRACK)) &&
                   (err_scaled <= win_scaled) && !fault_i; // RQ12

  // Messages accepted from the configured neighbours only.
  wire on_from_pre = rx_valid_reg && rx_msg_reg[`PMS_MSG_ON] &&
                     (rx_msg_reg[`PMS_MSG_ID] == chain_reg[`PMS_CHAIN_PRE]); // RQ23
  wire off_from_next = rx_valid_reg && !rx_msg_reg[`PMS_MSG_ON] &&
                       (rx_msg_reg[`PMS_MSG_ID] == chain_reg[`PMS_CHAIN_NEXT]); // RQ23

  // Main sequencer, register writes and readback.
  always @(posedge mclk_i) begin
    if (reset_i) begin
      state_reg <= ST_INIT;
      init_cnt_reg <= 32'h0;
      op_reg <= `PMS_RST_OPERATION;
      ensrc_reg <= `PMS_RST_ENSRC;
      setpoint_reg <= `PMS_RST_ZERO16;
      slew_reg <= `PMS_RST_SLEW;
      ovwarn_reg <= `PMS_RST_OVWARN;
      goodwin_reg <= `PMS_RST_GOODWIN;
      ton_wait_reg <= `PMS_RST_TON_WAIT;
      ton_ramp_reg <= `PMS_RST_TON_RAMP;
      toff_wait_reg <= `PMS_RST_TOFF_WAIT;
      toff_ramp_reg <= `PMS_RST_TOFF_RAMP;
      pincfg_reg <= `PMS_RST_ZERO16;
      good_wait_reg <= `PMS_RST_ZERO16;
      chain_reg <= `PMS_RST_ZERO16;
      follow_reg <= `PMS_RST_ZERO8;
      wait_cnt_reg <= 16'h0;
      pin_on_reg <= 1'b0;
      inhibit_reg <= 1'b0;
      acc_reg <= 32'h0;
      span_reg <= 32'h0;
      ramp_cyc_reg <= 32'h0;
      dir_up_reg <= 1'b1;
      goal_reg <= 16'h0;
      catch_reg <= 1'b0;
      limit_reg <= 16'h0;
      tx_req_reg <= 1'b0;
      tx_on_reg <= 1'b0;
      vout_ref_o <= 16'h0;
      switching_o <= 1'b0;
      bus_address_o <= 5'h0;
      cmd_rdata_o <= 16'h0;
      cmd_ready_o <= 1'b0;
    end else begin
      tx_req_reg <= 1'b0;
      cmd_ready_o <= ready;
      // Pin edges count only while the output is settled on or off.
      if (ready && stable && en_rise) begin
        pin_on_reg <= 1'b1; // RQ6 RQ8
      end else if (ready && stable && en_fall) begin
        pin_on_reg <= 1'b0; // RQ6 RQ8
      end
      if (!want_on) begin
        inhibit_reg <= 1'b0;
      end
      // Bus writes land in volatile copies and outrank every store.
      if (ready && cmd_wr_i) begin // RQ2 RQ3
        case (cmd_code_i)
          `PMS_CMD_OPERATION: op_reg <= cmd_wdata_i[7:0]; // RQ7
          `PMS_CMD_ENSRC: ensrc_reg <= cmd_wdata_i[7:0]; // RQ7
          `PMS_CMD_SETPOINT: setpoint_reg <= cmd_wdata_i; // RQ4
          `PMS_CMD_SLEW: slew_reg <= cmd_wdata_i;
          `PMS_CMD_OVWARN: ovwarn_reg <= cmd_wdata_i;
          `PMS_CMD_GOODWIN: goodwin_reg <= cmd_wdata_i;
          `PMS_CMD_TON_WAIT: ton_wait_reg <= cmd_wdata_i;
          `PMS_CMD_TON_RAMP: ton_ramp_reg <= cmd_wdata_i;
          `PMS_CMD_TOFF_WAIT: toff_wait_reg <= cmd_wdata_i;
          `PMS_CMD_TOFF_RAMP: toff_ramp_reg <= cmd_wdata_i;
          `PMS_CMD_PINCFG: pincfg_reg <= cmd_wdata_i;
          `PMS_CMD_GOOD_WAIT: good_wait_reg <= cmd_wdata_i;
          `PMS_CMD_CHAIN: chain_reg <= cmd_wdata_i;
          `PMS_CMD_FOLLOW: follow_reg <= cmd_wdata_i[7:0];
          default: op_reg <= op_reg;
        endcase
      end
      // Readback; unknown codes and reads during start-up return zero.
      if (cmd_rd_i) begin
        case (ready ? cmd_code_i : 8'h00)
          `PMS_CMD_OPERATION: cmd_rdata_o <= {8'h00, op_reg};
          `PMS_CMD_ENSRC: cmd_rdata_o <= {8'h00, ensrc_reg};
          `PMS_CMD_SETPOINT: cmd_rdata_o <= setpoint_reg;
          `PMS_CMD_SLEW: cmd_rdata_o <= slew_reg;
          `PMS_CMD_OVWARN: cmd_rdata_o <= ovwarn_reg;
          `PMS_CMD_GOODWIN: cmd_rdata_o <= goodwin_reg;
          `PMS_CMD_TON_WAIT: cmd_rdata_o <= ton_wait_reg;
          `PMS_CMD_TON_RAMP: cmd_rdata_o <= ton_ramp_reg;
          `PMS_CMD_TOFF_WAIT: cmd_rdata_o <= toff_wait_reg;
          `PMS_CMD_TOFF_RAMP: cmd_rdata_o <= toff_ramp_reg;
          `PMS_CMD_PINCFG: cmd_rdata_o <= pincfg_reg;
          `PMS_CMD_GOOD_WAIT: cmd_rdata_o <= good_wait_reg;
          `PMS_CMD_CHAIN: cmd_rdata_o <= chain_reg;
          `PMS_CMD_FOLLOW: cmd_rdata_o <= {8'h00, follow_reg};
          `PMS_CMD_STATUS: cmd_rdata_o <= {good_reg, switching_o, inhibit_reg, 2'b00, state_reg};
          default: cmd_rdata_o <= 16'h0;
        endcase
      end
      case (state_reg)
        // Load order: defaults at reset, then strap, then user store.
        ST_INIT: begin
          if (por_ok) begin // RQ1
            init_cnt_reg <= init_cnt_reg + 32'h1;
            if (init_cnt_reg == 32'h0) begin
              bus_address_o <= strap_divider_input_i[`PMS_STRAP_ADDR]; // RQ4
              setpoint_reg <= strap_fault_i ? `PMS_FALLBACK_MV : strap_mv; // RQ4 RQ5
            end else if (init_cnt_reg == 32'h2 && nv_setpoint_valid_i) begin
              setpoint_reg <= nv_setpoint_i; // RQ3 RQ5
            end else if (init_cnt_reg >= INIT_CYCLES - 1) begin
              state_reg <= ST_OFF; // RQ2
            end
          end else begin
            init_cnt_reg <= 32'h0;
          end
        end
        // Off: tracking skips every delay and ramp setting.
        ST_OFF: begin
          switching_o <= 1'b0;
          vout_ref_o <= 16'h0;
          if (want_on && fol_en) begin
            limit_reg <= setpoint_reg;
            catch_reg <= (ref_in != 16'h0); // RQ20
            state_reg <= ST_TRACK; // RQ18
          end else if (want_on && !inhibit_reg) begin
            wait_cnt_reg <= on_wait; // RQ10
            state_reg <= has_pre ? ST_WAITPRE : ST_DELAY; // RQ21
          end
        end
        // Wait for the previous module to report its output good.
        ST_WAITPRE: begin
          if (!want_on) begin
            state_reg <= ST_OFF;
          end else if (on_from_pre) begin
            state_reg <= ST_DELAY; // RQ21
          end
        end
        // Turn-on delay, then the pre-bias decision.
        ST_DELAY: begin
          if (tick) begin
            wait_cnt_reg <= wait_cnt_reg - 16'h1; // RQ10
          end
          if (tick && wait_cnt_reg == 16'h1) begin
            acc_reg <= 32'h0;
            ramp_cyc_reg <= rise_cyc; // RQ11
            goal_reg <= target;
            if (vout_meas_i > ovwarn_reg) begin
              inhibit_reg <= 1'b1; // RQ16
              state_reg <= ST_OFF; // RQ16
            end else if (vout_meas_i < target) begin
              vout_ref_o <= vout_meas_i; // RQ14
              switching_o <= 1'b1; // RQ14
              span_reg <= {16'h0, target - vout_meas_i};
              dir_up_reg <= 1'b1;
              state_reg <= ST_RAMP; // RQ14
            end else begin
              wait_cnt_reg <= ton_ramp_reg;
              state_reg <= ST_HOLD; // RQ15
            end
          end
        end
        // High pre-bias: stay idle for the rise time, then ramp down.
        ST_HOLD: begin
          if (tick && wait_cnt_reg != 16'h0) begin
            wait_cnt_reg <= wait_cnt_reg - 16'h1;
          end
          if (wait_cnt_reg == 16'h0) begin
            vout_ref_o <= vout_meas_i; // RQ15
            switching_o <= 1'b1; // RQ15
            span_reg <= {16'h0, vout_meas_i - goal_reg};
            dir_up_reg <= 1'b0;
            state_reg <= ST_RAMP; // RQ15
          end
        end
        // Even stepping: one millivolt each time span cycles pass the ramp length.
        ST_RAMP, ST_FALL: begin
          if (vout_ref_o == goal_reg || ramp_cyc_reg == 32'h0) begin
            vout_ref_o <= goal_reg;
            if (state_reg == ST_RAMP) begin
              state_reg <= ST_ON;
            end else begin
              switching_o <= 1'b0;
              tx_on_reg <= 1'b0;
              tx_req_reg <= has_pre; // RQ22
              state_reg <= ST_OFF;
            end
          end else if (acc_reg + span_reg >= ramp_cyc_reg) begin
            acc_reg <= acc_reg + span_reg - ramp_cyc_reg; // RQ11
            vout_ref_o <= dir_up_reg ? vout_ref_o + 16'h1 : vout_ref_o - 16'h1; // RQ11
          end else begin
            acc_reg <= acc_reg + span_reg;
          end
        end
        // Regulating; soft off waits for the next module first.
        ST_ON: begin
          vout_ref_o <= target; // RQ4
          if (!want_on) begin
            if (soft_off) begin
              wait_cnt_reg <= off_wait; // RQ10
              state_reg <= has_next ? ST_OFFWAIT : ST_OFFDLY; // RQ22
            end else begin
              switching_o <= 1'b0;
              vout_ref_o <= 16'h0;
              state_reg <= ST_OFF;
            end
          end
        end
        // Wait until the next module has finished falling.
        ST_OFFWAIT: begin
          if (off_from_next) begin
            state_reg <= ST_OFFDLY; // RQ22
          end
        end
        // Turn-off delay, then the fall ramp.
        ST_OFFDLY: begin
          if (tick) begin
            wait_cnt_reg <= wait_cnt_reg - 16'h1; // RQ10
          end
          if (tick && wait_cnt_reg == 16'h1) begin
            acc_reg <= 32'h0;
            ramp_cyc_reg <= fall_cyc; // RQ11
            span_reg <= {16'h0, vout_ref_o};
            goal_reg <= 16'h0;
            dir_up_reg <= 1'b0;
            state_reg <= ST_FALL;
          end
        end
        // Tracking ignores enable; it ends when the mode is switched off.
        ST_TRACK: begin
          switching_o <= 1'b1;
          if (!fol_en) begin
            state_reg <= ST_OFF;
          end else if (catch_reg) begin
            if (trk_diff <= slew_reg) begin
              catch_reg <= 1'b0; // RQ20
            end else if (tick) begin
              vout_ref_o <= (vout_ref_o < trk_goal) ? vout_ref_o + slew_reg : vout_ref_o - slew_reg; // RQ20
            end
          end else begin
            vout_ref_o <= trk_goal; // RQ17 RQ18
          end
        end
        default: state_reg <= ST_INIT;
      endcase
      // Each rising of output good in the on state announces this rail to the next module.
      if (has_next && good_cond && good_wait_reg == 16'h0 && !good_reg && state_reg == ST_ON) begin
        tx_on_reg <= 1'b1;
        tx_req_reg <= 1'b1; // RQ21
      end else if (has_next && tick && good_cond && !good_reg && good_cnt_reg == 16'h1 &&
                   state_reg == ST_ON) begin
        tx_on_reg <= 1'b1;
        tx_req_reg <= 1'b1; // RQ21
      end
    end
  end

  // Output good delay: restarts whenever a condition drops.
  always @(posedge mclk_i) begin
    if (reset_i) begin
      good_reg <= 1'b0;
      good_cnt_reg <= 16'h0;
      output_ok_signal_o <= 1'b0;
    end else begin
      if (!good_cond) begin
        good_reg <= 1'b0; // RQ12
        good_cnt_reg <= good_wait_reg;
      end else if (good_cnt_reg == 16'h0) begin
        good_reg <= 1'b1; // RQ13
      end else if (tick) begin
        good_cnt_reg <= good_cnt_reg - 16'h1; // RQ13
      end
      output_ok_signal_o <= good_reg ^ pincfg_reg[`PMS_PIN_INV];
    end
  end

  // Link: start bit low, eight bits LSB first, sampled on rising link clock.
  always @(posedge mclk_i) begin
    if (reset_i) begin
      rx_sh_reg <= 8'h0;
      rx_cnt_reg <= 4'h0;
      rx_valid_reg <= 1'b0;
      rx_msg_reg <= 8'h0;
      tx_sh_reg <= 9'h1ff;
      tx_cnt_reg <= 4'h0;
      imb_data_o <= 1'b0;
      imb_data_oe_o <= 1'b0;
    end else begin
      rx_valid_reg <= 1'b0;
      if (lk_rise) begin
        if (rx_cnt_reg == 4'h0) begin
          rx_cnt_reg <= lk_data ? 4'h0 : 4'h8;
        end else begin
          rx_sh_reg <= {lk_data, rx_sh_reg[7:1]};
          rx_cnt_reg <= rx_cnt_reg - 4'h1;
          if (rx_cnt_reg == 4'h1) begin
            rx_msg_reg <= {lk_data, rx_sh_reg[7:1]}; // RQ23
            rx_valid_reg <= 1'b1;
          end
        end
      end
      // Sender shifts on falling link clock; a request while busy is dropped.
      if (tx_req_reg && tx_cnt_reg == 4'h0) begin
        tx_sh_reg <= {tx_on_reg, 2'b00, bus_address_o, 1'b0}; // RQ23
        tx_cnt_reg <= 4'h9;
      end else if (lk_fall) begin
        if (tx_cnt_reg != 4'h0) begin
          imb_data_oe_o <= ~tx_sh_reg[0];
          tx_sh_reg <= {1'b1, tx_sh_reg[8:1]};
          tx_cnt_reg <= tx_cnt_reg - 4'h1;
        end else begin
          imb_data_oe_o <= 1'b0;
        end
      end
    end
  end

endmodule

`default_nettype wire

// file: verif/pms_props.sv
// Port checker of the power sequencer.
`timescale 1ns/100ps
`default_nettype none
module pms_props (
  input wire mclk_i, reset_i, cmd_wr_i, cmd_rd_i, fault_i,
  input wire cmd_ready_o, output_ok_signal_o, switching_o, imb_data_o, imb_data_oe_o,
  input wire [7:0] cmd_code_i,
  input wire [15:0] cmd_wdata_i, cmd_rdata_o,
  input wire [4:0] bus_address_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  property p_init; $fell(reset_i) |-> !cmd_ready_o [*8]; endproperty
  a_init: assert property (p_init) else $error("early ready");
  property p_keep; cmd_ready_o |=> cmd_ready_o; endproperty
  a_keep: assert property (p_keep) else $error("ready lost");
  property p_addr; cmd_ready_o && $past(cmd_ready_o) |-> $stable(bus_address_o); endproperty
  a_addr: assert property (p_addr) else $error("address moved");
  property p_unk; cmd_ready_o && cmd_rd_i && cmd_code_i == 8'h00 |=> cmd_rdata_o == 16'h0000; endproperty
  a_unk: assert property (p_unk) else $error("unmapped read");
  property p_wr; cmd_ready_o && cmd_wr_i && cmd_code_i == 8'h27 ##2 cmd_rd_i && cmd_code_i == 8'h27
    |=> cmd_rdata_o == $past(cmd_wdata_i, 3); endproperty
  a_wr: assert property (p_wr) else $error("write lost");
  property p_flt; fault_i [*3] |-> !output_ok_signal_o; endproperty
  a_flt: assert property (p_flt) else $error("good in fault");
  property p_ok; $rose(output_ok_signal_o) |-> $past(switching_o); endproperty
  a_ok: assert property (p_ok) else $error("good while off");
  property p_link; !imb_data_o && (!imb_data_oe_o || cmd_ready_o); endproperty
  a_link: assert property (p_link) else $error("link drive");
endmodule
bind pms_power_sequencer pms_props chk_u (.mclk_i(mclk_i), .reset_i(reset_i), .cmd_wr_i(cmd_wr_i),
  .cmd_rd_i(cmd_rd_i), .fault_i(fault_i), .cmd_ready_o(cmd_ready_o), .switching_o(switching_o),
  .output_ok_signal_o(output_ok_signal_o), .imb_data_o(imb_data_o), .imb_data_oe_o(imb_data_oe_o),
  .cmd_code_i(cmd_code_i), .cmd_wdata_i(cmd_wdata_i), .cmd_rdata_o(cmd_rdata_o), .bus_address_o(bus_address_o));
`default_nettype wire

// file: verif/pms_peer.sv
// Peer module on the link, sending one frame on request.
`timescale 1ns/100ps
`default_nettype none
module pms_peer (
  output logic link_clk_o,
  output logic pull_o
);
  // The link clock stands high between frames.
  initial begin
    link_clk_o = 1'b1;
    pull_o = 1'b0;
  end
  // Start bit, then eight bits with the lowest first, changed on falling edges.
  task automatic send(input logic [7:0] msg);
    for (int i = 0; i < 10; i++) begin
      link_clk_o = 1'b0;
      pull_o = (i == 0) ? 1'b1 : (i < 9) ? ~msg[(i + 7) % 8] : 1'b0;
      #400 link_clk_o = 1'b1;
      #400;
    end
  endtask
endmodule
`default_nettype wire

// file: verif/pms_power_sequencer_test.sv
// Self-checking bench of the power sequencer.
`timescale 1ns/100ps
`default_nettype none
module pms_power_sequencer_test;
  logic mclk_i = 0, reset_i = 1, en = 0, wr = 0, rd = 0, hi = 0, flt = 0, rdy, sw, ok, oe, lclk, pull;
  logic por = 1, sfl = 0, nvv = 0;
  logic [7:0] code = 0, strap = 0;
  logic [15:0] wd = 0, rdata, vref, ev, nvs = 0, fref = 0;
  logic [4:0] addr;
  logic [31:0] seed = 32'haa41;
  int n_fail = 0, cmp_count = 0;
  logic [7:0] rc [10] = '{8'h01, 8'h02, 8'h27, 8'h57, 8'h5e, 8'h60, 8'h61, 8'h64, 8'h65, 8'h00};
  logic [15:0] rv [10] = '{16'h0, 16'h5, 16'h1, 16'h960, 16'ha, 16'h32, 16'h32, 16'h0, 16'h32, 16'h0};
  logic [15:0] sp [8] = '{16'h258, 16'h2ee, 16'h384, 16'h3e8, 16'h44c, 16'h4b0, 16'h5dc, 16'h708};
  always #50 mclk_i = ~mclk_i;
  pms_peer peer_u (.link_clk_o(lclk), .pull_o(pull));
  pms_power_sequencer #(.INIT_CYCLES(50), .TICK_CYCLES(10)) dut_u (.mclk_i(mclk_i), .reset_i(reset_i),
    .por_ok_i(por), .strap_divider_input_i(strap), .strap_fault_i(sfl), .nv_setpoint_valid_i(nvv),
    .nv_setpoint_i(nvs), .enable_pin_i(en), .cmd_wr_i(wr), .cmd_rd_i(rd), .cmd_code_i(code),
    .cmd_wdata_i(wd), .cmd_rdata_o(rdata), .cmd_ready_o(rdy), .vout_meas_i(hi ? 16'hbb8 : sw ? vref : 16'h0),
    .fault_i(flt), .follow_reference_input_i(fref), .vout_ref_o(vref), .switching_o(sw),
    .output_ok_signal_o(ok), .bus_address_o(addr), .imb_clk_i(lclk), .imb_data_i(~(pull | oe)),
    .imb_data_o(), .imb_data_oe_o(oe));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Inputs move 5 ns after the rising edge.
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
    #5;
  endtask
  task automatic acc(input logic w, input logic [7:0] c, input logic [15:0] d);
    {wr, rd, code, wd} = {w, ~w, c, d};
    cyc(1);
    {wr, rd} = 2'b00;
    cyc(1);
  endtask
  task automatic wait_lvl(ref logic s, input logic v, input int lim);
    for (int i = 0; i < lim && s !== v; i++) cyc(1);
    chk(16'(s), 16'(v));
  endtask
  task automatic close_out();
    if (n_fail == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // The whole run needs well under a millisecond.
  initial begin
    #1000000;
    n_fail++;
    close_out();
  end
  initial begin
    strap = 8'(rnd());
    cyc(16);
    reset_i = 0;
    wait_lvl(rdy, 1'b1, 200);
    chk(16'(addr), 16'(strap[4:0]));
    acc(1'b0, 8'h21, 16'h0);
    chk(rdata, sp[strap[7:5]]);
    foreach (rc[i]) begin
      acc(1'b0, rc[i], 16'h0);
      chk(rdata, rv[i]);
    end
    repeat (3) begin
      ev = 16'(rnd());
      acc(1'b1, 8'h27, ev);
      acc(1'b0, 8'h27, 16'h0);
      chk(rdata, ev);
    end
    acc(1'b1, 8'h60, 16'h0);
    acc(1'b1, 8'h61, 16'h0);
    acc(1'b1, 8'h65, 16'h0);
    en = 1;
    wait_lvl(sw, 1'b1, 40);
    cyc(3);
    chk(vref, sp[strap[7:5]]);
    wait_lvl(ok, 1'b1, 20);
    en = 0;
    wait_lvl(sw, 1'b0, 40);
    peer_u.send(8'h83);
    cyc(1);
    chk(16'(sw), 16'h0);
    hi = 1;
    en = 1;
    cyc(40);
    chk(16'(sw), 16'h0);
    en = 0;
    hi = 0;
    cyc(10);
    en = 1;
    wait_lvl(ok, 1'b1, 60);
    flt = 1;
    wait_lvl(ok, 1'b0, 5);
    en = 0;
    flt = 0;
    wait_lvl(sw, 1'b0, 40);
    acc(1'b1, 8'he1, 16'h1);
    acc(1'b1, 8'h02, 16'h0);
    cyc(20);
    fref = 16'h64;
    cyc(2);
    chk(vref, 16'h64);
    fref = 16'hffff;
    cyc(2);
    chk(vref, sp[strap[7:5]]);
    repeat (2) begin
      reset_i = 1;
      sfl = 1;
      nvv = ~nvv;
      nvs = 16'(rnd());
      cyc(4);
      reset_i = 0;
      wait_lvl(rdy, 1'b1, 200);
      acc(1'b0, 8'h21, 16'h0);
      chk(rdata, nvv ? nvs : 16'h708);
    end
    cyc(3);
    close_out();
  end
endmodule
`default_nettype wire
